// ---- hdl/spi_pkg.sv ----
// Package for the SPI master/slave controller: register map, field positions,
// reset values, pin carriers, engine states and shared helpers.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package spi_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_DATA  = 8'h08;
  localparam logic [7:0] OFF_DACC  = 8'h0c;
  localparam logic [7:0] OFF_CTL2  = 8'h10;
  localparam logic [7:0] OFF_DACC2 = 8'h14;
  localparam logic [7:0] OFF_SSLP  = 8'h18;
  localparam logic [7:0] OFF_BRATE = 8'h1c;
  localparam logic [7:0] OFF_CMD   = 8'h20;
  // Main control fields
  localparam int CTL_EN = 0, CTL_MST = 1, CTL_MM = 2, CTL_TXO = 3;
  localparam int CTL_LOOP = 4, CTL_OD = 5, CTL_3W = 6, CTL_INIT = 7;
  // Error flag positions
  localparam int ER_OVR = 0, ER_PERR = 1, ER_MODE_FAULT_FLAG = 2, ER_UDR = 3;
  // Status read layout
  localparam int ST_OVR = 0, ST_IDLE = 1, ST_MODE_FAULT_FLAG = 2, ST_PERR = 3;
  localparam int ST_UDR = 4, ST_TXE = 5, ST_RXF = 6;
  // Data access control fields
  localparam int DA_FRM = 0, DA_BYTE = 4, DA_LONG = 5;
  // Second control register fields
  localparam int C2_PE = 0, C2_PODD = 1, C2_ASE = 2, C2_IE = 4;
  // Second data access control field
  localparam int D2_SWAP = 0;
  // Select control fields
  localparam int SP_POL = 0, SP_LAST = 4, SP_IDLE = 7;
  // Command entry fields
  localparam int CMD_CPOL = 0, CMD_CPHA = 1, CMD_LSB = 2, CMD_BURST = 3;
  localparam int CMD_SSL = 4, CMD_LEN = 6, CMD_SCKD = 10, CMD_NEGD = 13;
  localparam int CMD_NXTD = 16, CMD_BRDV = 19;
  // Reset values
  localparam logic [7:0]  RST_REG8  = 8'h00;
  localparam logic [10:0] RST_BRATE = 11'h000;
  localparam logic [31:0] RST_CMD   = 32'h0000_0700;

  typedef enum logic [2:0] {
    E_IDLE  = 3'b000,
    E_LEAD  = 3'b001,
    E_SHIFT = 3'b010,
    E_HOLD  = 3'b011,
    E_LAG   = 3'b100,
    E_NEXT  = 3'b101
  } eng_t;

  typedef struct packed {
    logic       sck;
    logic       mosi;
    logic       miso;
    logic       ssl0;
  } pins_in_t;

  typedef struct packed {
    logic       sck_o;
    logic       sck_oe;
    logic       mosi_o;
    logic       mosi_oe;
    logic       miso_o;
    logic       miso_oe;
    logic [3:0] ssl_o;
    logic [3:0] ssl_oe;
  } pins_out_t;

  // Length code: 0..8 give 8..16 bits, 9/10/11 give 20/24/32
  function automatic logic [5:0] frame_bits(input logic [3:0] code);
    case (code)
      4'h9:    frame_bits = 6'd20;
      4'ha:    frame_bits = 6'd24;
      4'hb:    frame_bits = 6'd32;
      default: frame_bits = (code > 4'h8) ? 6'd8 : 6'd8 + {2'b00, code};
    endcase
  endfunction : frame_bits

  function automatic logic [31:0] frame_mask(input logic [5:0] nd);
    frame_mask = 32'((33'h1 << nd) - 33'h1);
  endfunction : frame_mask

  // Access width and optional byte swap between data window and buffer
  function automatic logic [31:0] fit(input logic [31:0] d, input logic byt,
                                      input logic lng, input logic swp);
    if (byt)
      fit = {24'h0, d[7:0]};
    else if (lng)
      fit = swp ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    else
      fit = swp ? {16'h0, d[7:0], d[15:8]} : {16'h0, d[15:0]};
  endfunction : fit

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] be);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i])
        merge[i*8 +: 8] = d[i*8 +: 8];
    end
  endfunction : merge
endpackage : spi_pkg

// ---- hdl/spi_ctrl.sv ----
// SPI master/slave controller with command sequencer and 4-frame buffers.
// Assumes an Avalon-MM master on clk; pins arrive unsynchronised.
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Four-wire SPI or three-wire without select
// - Full-duplex or transmit-only selectable
// - Clock polarity and phase selectable
// - MSB-first or LSB-first shifting
// - Frame lengths 8..16, 20, 24, 32
// - 128-bit double buffers, one to four frames
// - Optional byte swap at data window
// - Master clock divides peripheral clock 2..32768
// - Mode fault, overrun, parity, underrun detected
// - Select pin directions follow the mode
// - Three select delays of 1..8 clocks
// - Per-pin selectable select polarity
// - Eight looping command entries in master
// - Transmit buffer write starts master transfer
// - Idle data-out level set by software
// - Optional clock auto-stop when buffers unready
// - Four interrupt requests: rx, tx, error, idle
// - Mode fault flag also shows underrun
// - Parity appended and checked when enabled
// - Data window width: long, word or byte
// - Open-drain option, soft initialise, loopback
module spi_ctrl (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [7:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire spi_pkg::pins_in_t pins_in,
  output spi_pkg::pins_out_t     pins_out,
  output logic [3:0]             irq
);
  typedef struct packed {
    spi_pkg::eng_t      st;
    logic [7:0]         ctrl;
    logic [3:0]         errs;
    logic [7:0]         dacc;
    logic [7:0]         ctl2;
    logic [7:0]         dacc2;
    logic [7:0]         sslp;
    logic [10:0]        brate;
    logic [7:0][31:0]   cmd;
    logic [3:0][31:0]   txb;
    logic [3:0][31:0]   txs;
    logic [3:0][31:0]   rxs;
    logic [3:0][31:0]   rxb;
    logic [1:0]         txw;
    logic [1:0]         rxr;
    logic               txf;
    logic               rxf;
    logic [2:0]         ci;
    logic [1:0]         fi;
    logic [5:0]         bi;
    logic [13:0]        hc;
    logic               ph;
    logic [4:0]         dly;
    logic               rxp;
    logic               sck;
    logic               mosi;
    logic               miso;
    logic               act;
    spi_pkg::pins_in_t  s1;
    spi_pkg::pins_in_t  s2;
    logic               sck_d;
    logic               wt;
    logic [31:0]        rdata;
    logic [3:0]         irq;
    spi_pkg::pins_out_t po;
  } state_t;

  state_t      r_reg;
  state_t      r_next;
  logic [31:0] c;
  logic [5:0]  nd;
  logic [5:0]  nt;
  logic [1:0]  nfr;
  logic [13:0] hr;
  logic        en, mst, txo, cpol, cpha, pe, podd, sel_in, tick, lead, trail, rxd;
  logic        drv, reload, rb, bus_do;
  logic [31:0] w;
  logic [4:0]  pos;

  always_comb begin
    r_next = r_reg;
    drv    = 1'b0;
    reload = 1'b0;
    w      = '0;
    pos    = '0;
    c      = r_reg.cmd[r_reg.ci];
    nd     = spi_pkg::frame_bits(c[spi_pkg::CMD_LEN +: 4]);
    pe     = r_reg.ctl2[spi_pkg::C2_PE];
    podd   = r_reg.ctl2[spi_pkg::C2_PODD];
    nt     = nd + {5'd0, pe};
    nfr    = r_reg.dacc[spi_pkg::DA_FRM +: 2];
    en     = r_reg.ctrl[spi_pkg::CTL_EN];
    mst    = r_reg.ctrl[spi_pkg::CTL_MST];
    txo    = r_reg.ctrl[spi_pkg::CTL_TXO];
    cpol   = c[spi_pkg::CMD_CPOL];
    cpha   = c[spi_pkg::CMD_CPHA];
    // Half-period reload; ratio 2*(brate+1) scaled per command
    hr     = 14'((14'(r_reg.brate) + 14'd1) << c[spi_pkg::CMD_BRDV +: 2]) - 14'd1;
    tick   = (r_reg.hc == 14'd0);
    // Three-wire mode treats the slave as always selected
    sel_in = r_reg.ctrl[spi_pkg::CTL_3W] | (r_reg.s2.ssl0 == r_reg.sslp[spi_pkg::SP_POL]);
    // In master mode, loopback feeds data-out straight back into the receiver
    rxd    = mst ? (r_reg.ctrl[spi_pkg::CTL_LOOP] ? r_reg.mosi : r_reg.s2.miso)
                 : r_reg.s2.mosi;
    // Slave edges rely on the master keeping each clock phase two cycles long
    if (mst) begin
      lead  = (r_reg.st == spi_pkg::E_SHIFT) && tick && !r_reg.ph;
      trail = (r_reg.st == spi_pkg::E_SHIFT) && tick && r_reg.ph;
    end else begin
      lead  = (r_reg.st == spi_pkg::E_SHIFT) && sel_in && (r_reg.s2.sck != r_reg.sck_d)
              && (r_reg.sck_d == cpol);
      trail = (r_reg.st == spi_pkg::E_SHIFT) && sel_in && (r_reg.s2.sck != r_reg.sck_d)
              && (r_reg.sck_d != cpol);
    end

    // Synchronisers: only the second stage is read
    r_next.s1    = pins_in;
    r_next.s2    = r_reg.s1;
    r_next.sck_d = r_reg.s2.sck;
    r_next.hc    = tick ? hr : r_reg.hc - 14'd1;

    // Bus slave: one wait cycle, action at the edge waitrequest is low
    bus_do   = (read | write) && !r_reg.wt;
    r_next.wt = !((read | write) && r_reg.wt);
    // Read data only moves on a read, so it stands until the next one
    if (read && r_reg.wt) begin
      case (address[7:2])
        spi_pkg::OFF_CTRL[7:2]:  r_next.rdata = {24'h0, r_reg.ctrl};
        spi_pkg::OFF_STAT[7:2]:  r_next.rdata = {25'h0, r_reg.rxf, !r_reg.txf, r_reg.errs[spi_pkg::ER_UDR],
                                   r_reg.errs[spi_pkg::ER_PERR],
                                   r_reg.errs[spi_pkg::ER_MODE_FAULT_FLAG] | r_reg.errs[spi_pkg::ER_UDR],
                                   (r_reg.st == spi_pkg::E_IDLE) && !r_reg.txf, r_reg.errs[spi_pkg::ER_OVR]};
        spi_pkg::OFF_DATA[7:2]:  r_next.rdata = spi_pkg::fit(r_reg.rxb[r_reg.rxr], r_reg.dacc[spi_pkg::DA_BYTE],
                                   r_reg.dacc[spi_pkg::DA_LONG], r_reg.dacc2[spi_pkg::D2_SWAP]);
        spi_pkg::OFF_DACC[7:2]:  r_next.rdata = {24'h0, r_reg.dacc};
        spi_pkg::OFF_CTL2[7:2]:  r_next.rdata = {24'h0, r_reg.ctl2};
        spi_pkg::OFF_DACC2[7:2]: r_next.rdata = {24'h0, r_reg.dacc2};
        spi_pkg::OFF_SSLP[7:2]:  r_next.rdata = {24'h0, r_reg.sslp};
        spi_pkg::OFF_BRATE[7:2]: r_next.rdata = {21'h0, r_reg.brate};
        default: begin
          if (address[7:5] == spi_pkg::OFF_CMD[7:5])
            r_next.rdata = r_reg.cmd[address[4:2]];
          else
            r_next.rdata = 32'h0;
        end
      endcase
    end
    if (bus_do && write) begin
      w = spi_pkg::merge(32'h0, writedata, byteenable);
      case (address[7:2])
        spi_pkg::OFF_CTRL[7:2]: begin
          if (byteenable[0])
            r_next.ctrl = {1'b0, w[6:0]};
          if (byteenable[0] && w[spi_pkg::CTL_INIT]) begin
            r_next.st   = spi_pkg::E_IDLE;
            r_next.txf  = 1'b0;
            r_next.rxf  = 1'b0;
            r_next.txw  = 2'd0;
            r_next.rxr  = 2'd0;
            r_next.errs = 4'h0;
            r_next.ci   = 3'd0;
            r_next.act  = 1'b0;
          end
        end
        spi_pkg::OFF_STAT[7:2]: begin
          // Write one to clear; a same-cycle event below still wins
          r_next.errs = r_reg.errs & ~{w[spi_pkg::ST_UDR], w[spi_pkg::ST_MODE_FAULT_FLAG], w[spi_pkg::ST_PERR],
                                       w[spi_pkg::ST_OVR]};
        end
        spi_pkg::OFF_DATA[7:2]: begin
          // Writes while the buffer is still full are dropped
          if (!r_reg.txf) begin
            r_next.txb[r_reg.txw] = spi_pkg::fit(writedata, r_reg.dacc[spi_pkg::DA_BYTE],
                                    r_reg.dacc[spi_pkg::DA_LONG], r_reg.dacc2[spi_pkg::D2_SWAP]);
            r_next.txw = r_reg.txw + 2'd1;
            if (r_reg.txw == nfr) begin
              r_next.txf = 1'b1;
              r_next.txw = 2'd0;
            end
          end
        end
        spi_pkg::OFF_DACC[7:2]:  r_next.dacc  = 8'(spi_pkg::merge({24'h0, r_reg.dacc}, writedata, byteenable));
        spi_pkg::OFF_CTL2[7:2]:  r_next.ctl2  = 8'(spi_pkg::merge({24'h0, r_reg.ctl2}, writedata, byteenable));
        spi_pkg::OFF_DACC2[7:2]: r_next.dacc2 = 8'(spi_pkg::merge({24'h0, r_reg.dacc2}, writedata, byteenable));
        spi_pkg::OFF_SSLP[7:2]:  r_next.sslp  = 8'(spi_pkg::merge({24'h0, r_reg.sslp}, writedata, byteenable));
        spi_pkg::OFF_BRATE[7:2]: r_next.brate = 11'(spi_pkg::merge({21'h0, r_reg.brate}, writedata, byteenable));
        default: begin
          if (address[7:5] == spi_pkg::OFF_CMD[7:5])
            r_next.cmd[address[4:2]] = spi_pkg::merge(r_reg.cmd[address[4:2]], writedata, byteenable);
        end
      endcase
    end
    if (bus_do && read && (address[7:2] == spi_pkg::OFF_DATA[7:2]) && r_reg.rxf) begin
      r_next.rxr = r_reg.rxr + 2'd1;
      if (r_reg.rxr == nfr) begin
        r_next.rxf = 1'b0;
        r_next.rxr = 2'd0;
      end
    end
    rb = !txo && r_next.rxf;

    // Serial engine
    case (r_reg.st)
      spi_pkg::E_IDLE: begin
        r_next.act = 1'b0;
        if (en && mst && r_reg.txf) begin
          reload        = 1'b1;
          r_next.st     = spi_pkg::E_LEAD;
          r_next.hc     = hr;
          r_next.act    = 1'b1;
          r_next.sck    = cpol;
          r_next.dly    = 5'((5'(c[spi_pkg::CMD_SCKD +: 3]) + 5'd1) << 1);
        end else if (en && !mst && sel_in) begin
          r_next.st  = spi_pkg::E_SHIFT;
          r_next.act = 1'b1;
          r_next.fi  = 2'd0;
          r_next.bi  = 6'd0;
          drv        = !cpha;
          if (r_reg.txf)
            reload = 1'b1;
          else
            r_next.errs[spi_pkg::ER_UDR] = 1'b1;
        end
      end
      spi_pkg::E_LEAD: begin
        if (tick) begin
          r_next.dly = r_reg.dly - 5'd1;
          if (r_reg.dly == 5'd1) begin
            r_next.st = spi_pkg::E_SHIFT;
            r_next.ph = 1'b0;
            drv       = !cpha;
          end
        end
      end
      spi_pkg::E_SHIFT: begin
        if (lead) begin
          r_next.ph = 1'b1;
          if (mst)
            r_next.sck = !cpol;
          drv = cpha;
        end
        if (lead ^ trail && ((lead && !cpha) || (trail && cpha))) begin
          if (r_reg.bi < nd) begin
            pos = 5'(c[spi_pkg::CMD_LSB] ? r_reg.bi : nd - 6'd1 - r_reg.bi);
            r_next.rxs[r_reg.fi][pos] = rxd;
          end else begin
            r_next.rxp = rxd;
          end
        end
        if (trail) begin
          r_next.ph = 1'b0;
          if (mst)
            r_next.sck = cpol;
          if (r_reg.bi != nt - 6'd1) begin
            r_next.bi = r_reg.bi + 6'd1;
            drv       = !cpha;
          end else begin
            if (pe && !txo && ((^(r_next.rxs[r_reg.fi] & spi_pkg::frame_mask(nd))) ^ podd) != r_next.rxp)
              r_next.errs[spi_pkg::ER_PERR] = 1'b1;
            r_next.bi = 6'd0;
            if (r_reg.fi != nfr) begin
              r_next.fi = r_reg.fi + 2'd1;
              drv       = !cpha;
            end else begin
              if (!txo) begin
                if (r_next.rxf)
                  r_next.errs[spi_pkg::ER_OVR] = 1'b1;
                else begin
                  r_next.rxb = r_next.rxs;
                  r_next.rxf = 1'b1;
                  r_next.rxr = 2'd0;
                end
              end
              if (!mst) begin
                drv = !cpha;
                if (r_reg.txf)
                  reload = 1'b1;
                else
                  r_next.errs[spi_pkg::ER_UDR] = 1'b1;
              end else begin
                r_next.ci = (r_reg.ci == r_reg.sslp[spi_pkg::SP_LAST +: 3]) ? 3'd0 : r_reg.ci + 3'd1;
                if (c[spi_pkg::CMD_BURST] && r_reg.txf && !(r_reg.ctl2[spi_pkg::C2_ASE] && rb)) begin
                  reload = 1'b1;
                  drv    = !cpha;
                end else if (c[spi_pkg::CMD_BURST] && r_reg.ctl2[spi_pkg::C2_ASE]) begin
                  r_next.st = spi_pkg::E_HOLD;
                end else begin
                  r_next.st  = spi_pkg::E_LAG;
                  r_next.dly = 5'((5'(c[spi_pkg::CMD_NEGD +: 3]) + 5'd1) << 1);
                end
              end
            end
          end
        end
        if (!mst && !sel_in) begin
          if (r_reg.bi != 6'd0 || r_reg.fi != 2'd0)
            r_next.errs[spi_pkg::ER_MODE_FAULT_FLAG] = 1'b1;
          r_next.st = spi_pkg::E_IDLE;
        end
      end
      spi_pkg::E_HOLD: begin
        // Clock parked at idle level until both buffers are ready
        if (r_reg.txf && !rb) begin
          reload     = 1'b1;
          r_next.st  = spi_pkg::E_SHIFT;
          r_next.ph  = 1'b0;
          r_next.hc  = hr;
          drv        = !cpha;
        end
      end
      spi_pkg::E_LAG: begin
        if (tick) begin
          r_next.dly = r_reg.dly - 5'd1;
          if (r_reg.dly == 5'd1) begin
            r_next.st  = spi_pkg::E_NEXT;
            r_next.act = 1'b0;
            r_next.dly = 5'((5'(c[spi_pkg::CMD_NXTD +: 3]) + 5'd1) << 1);
          end
        end
      end
      spi_pkg::E_NEXT: begin
        if (tick) begin
          r_next.dly = r_reg.dly - 5'd1;
          if (r_reg.dly == 5'd1)
            r_next.st = spi_pkg::E_IDLE;
        end
      end
      default: r_next.st = spi_pkg::E_IDLE;
    endcase

    // Multi-master: another master selecting us aborts and disables
    if (en && mst && r_reg.ctrl[spi_pkg::CTL_MM]
        && (r_reg.s2.ssl0 == r_reg.sslp[spi_pkg::SP_POL])) begin
      r_next.errs[spi_pkg::ER_MODE_FAULT_FLAG] = 1'b1;
      r_next.ctrl[spi_pkg::CTL_EN]  = 1'b0;
      r_next.st                     = spi_pkg::E_IDLE;
      r_next.act                    = 1'b0;
    end
    if (!en && !(bus_do && write && address[7:2] == spi_pkg::OFF_CTRL[7:2]))
      r_next.st = spi_pkg::E_IDLE;

    if (reload) begin
      r_next.txs = r_reg.txb;
      r_next.txf = 1'b0;
      r_next.fi  = 2'd0;
      r_next.bi  = 6'd0;
    end
    if (drv) begin
      if (r_next.bi < nd) begin
        pos = 5'(c[spi_pkg::CMD_LSB] ? r_next.bi : nd - 6'd1 - r_next.bi);
        w   = r_next.txs[r_next.fi];
        if (mst)
          r_next.mosi = w[pos];
        else
          r_next.miso = w[pos];
      end else begin
        w = r_next.txs[r_next.fi] & spi_pkg::frame_mask(nd);
        if (mst)
          r_next.mosi = (^w) ^ podd;
        else
          r_next.miso = (^w) ^ podd;
      end
    end
    if (!r_next.act)
      r_next.mosi = r_reg.sslp[spi_pkg::SP_IDLE];
    if (r_next.st == spi_pkg::E_IDLE || r_next.st == spi_pkg::E_NEXT)
      r_next.sck = cpol;

    // Pin drive; open-drain drives only the low level on clock and data pins
    r_next.po.sck_o   = r_next.sck;
    r_next.po.mosi_o  = r_next.mosi;
    r_next.po.miso_o  = r_next.miso;
    r_next.po.sck_oe  = r_next.ctrl[spi_pkg::CTL_EN] && mst && (!r_reg.ctrl[spi_pkg::CTL_OD] || !r_next.sck);
    r_next.po.mosi_oe = r_next.ctrl[spi_pkg::CTL_EN] && mst && (!r_reg.ctrl[spi_pkg::CTL_OD] || !r_next.mosi);
    r_next.po.miso_oe = en && !mst && r_next.act && (!r_reg.ctrl[spi_pkg::CTL_OD] || !r_next.miso);
    for (int i = 0; i < 4; i++) begin
      r_next.po.ssl_o[i]  = (r_next.act && mst && c[spi_pkg::CMD_SSL +: 2] == 2'(i))
                            ? r_reg.sslp[spi_pkg::SP_POL + i] : !r_reg.sslp[spi_pkg::SP_POL + i];
      r_next.po.ssl_oe[i] = r_next.ctrl[spi_pkg::CTL_EN] && mst
                            && !(i == 0 && r_reg.ctrl[spi_pkg::CTL_MM]);
    end
    r_next.irq = r_reg.ctl2[spi_pkg::C2_IE +: 4]
                 & {(r_next.st == spi_pkg::E_IDLE) && !r_next.txf, |r_next.errs, !r_next.txf, r_next.rxf};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg       <= '0;
      r_reg.st    <= spi_pkg::E_IDLE;
      r_reg.ctrl  <= spi_pkg::RST_REG8;
      r_reg.dacc  <= spi_pkg::RST_REG8;
      r_reg.ctl2  <= spi_pkg::RST_REG8;
      r_reg.dacc2 <= spi_pkg::RST_REG8;
      r_reg.sslp  <= spi_pkg::RST_REG8;
      r_reg.brate <= spi_pkg::RST_BRATE;
      r_reg.cmd   <= {8{spi_pkg::RST_CMD}};
      r_reg.wt    <= 1'b1;
      r_reg.po    <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign readdata    = r_reg.rdata;
  assign waitrequest = r_reg.wt;
  assign pins_out    = r_reg.po;
  assign irq         = r_reg.irq;
endmodule : spi_ctrl
`default_nettype wire

// ---- sim/spi_ctrl_checker.sv ----
// Concurrent checks on the controller's bus and pin ports.
// Assumes it is bound to every spi_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module spi_ctrl_checker (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic [7:0]         address,
  input wire logic               read,
  input wire logic               write,
  input wire logic [31:0]        writedata,
  input wire logic [3:0]         byteenable,
  input wire logic [31:0]        readdata,
  input wire logic               waitrequest,
  input wire spi_pkg::pins_in_t  pins_in,
  input wire spi_pkg::pins_out_t pins_out,
  input wire logic [3:0]         irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic st_rd = read && !waitrequest && address[7:2] == spi_pkg::OFF_STAT[7:2];
  a_wait_single: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait");
  a_wait_release: assert property (!waitrequest |=> waitrequest)
    else $error("wait low for more than one cycle");
  a_wait_cause: assert property (!waitrequest |-> $past(read || write))
    else $error("answer without request");
  a_read_hold: assert property ($changed(readdata) |-> $past(read && waitrequest))
    else $error("read data moved without a read");
  a_status_merge: assert property (st_rd && readdata[spi_pkg::ST_UDR] |-> readdata[spi_pkg::ST_MODE_FAULT_FLAG])
    else $error("underrun not shown in mode fault bit");
  a_status_upper: assert property (st_rd |-> readdata[31:7] == 25'h0)
    else $error("status upper bits not zero");
  a_unmapped_zero: assert property (read && !waitrequest && address[7:6] != 2'h0 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_select_no_miso: assert property (|pins_out.ssl_oe |-> !pins_out.miso_oe)
    else $error("select driven while slave output driven");
  c_status_udr: cover property (st_rd && readdata[spi_pkg::ST_UDR]);
  c_sck_rise: cover property ($rose(pins_out.sck_o));
  c_data_write: cover property (write && !waitrequest && address == spi_pkg::OFF_DATA);
endmodule : spi_ctrl_checker
bind spi_ctrl spi_ctrl_checker spi_ctrl_checker_inst (.clk(clk), .rst_b(rst_b), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .pins_in(pins_in), .pins_out(pins_out), .irq(irq));
`default_nettype wire

// ---- sim/spi_slave_model.sv ----
// Behavioural SPI slave: mode 0, MSB first, eight-bit frames.
// Assumes an active-low select, pulled high when undriven.
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model #(parameter logic [7:0] REPLY = 8'h3c) (
  input  wire logic       sck,
  input  wire logic       sel_b,
  input  wire logic       mosi,
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] tx_reg;
  logic       last_reg = 1'b0;
  always @(negedge sel_b) tx_reg = REPLY;
  always @(posedge sck) if (!sel_b) got <= {got[6:0], mosi};
  always @(negedge sck) if (!sel_b) tx_reg <= {tx_reg[6:0], 1'b0};
  always @(posedge sel_b) last_reg <= tx_reg[7];
  // Released line flips, so a stale bit never passes
  assign miso = sel_b ? ~last_reg : tx_reg[7];
endmodule : spi_slave_model
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench: register table, master frames, slave underrun.
// Assumes spi_pkg and the slave model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
  logic               clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0;
  logic [7:0]         address = 8'h00;
  logic [31:0]        writedata = 32'h0, readdata, rd;
  logic [3:0]         byteenable = 4'hf;
  logic               waitrequest, miso, lsck = 1'b0, lmosi = 1'b0, lsel = 1'b1;
  logic [7:0]         got;
  logic [3:0]         irq;
  spi_pkg::pins_in_t  pins_in;
  spi_pkg::pins_out_t pins_out;
  int                 err_count = 0, comparisons = 0;
  row_t rows [7] = '{'{8'h10, 32'hf6, 32'hf6}, '{8'h0c, 32'h33, 32'h33}, '{8'h14, 32'h1, 32'h1},
    '{8'h18, 32'hff, 32'hff}, '{8'h1c, 32'h7ff, 32'h7ff}, '{8'h3c, 32'h1fffff, 32'h1fffff},
    '{8'h40, 32'h5a, 32'h0}};
  assign pins_in = '{sck: lsck, mosi: lmosi, miso: miso, ssl0: lsel};
  always #5 clk = ~clk;
  spi_ctrl spi_ctrl_inst (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .pins_in(pins_in), .pins_out(pins_out), .irq(irq));
  spi_slave_model spi_slave_model_inst (.sck(pins_out.sck_o), .mosi(pins_out.mosi_o), .miso(miso),
    .sel_b(pins_out.ssl_oe[0] ? pins_out.ssl_o[0] : 1'b1), .got(got));
  task automatic final_report;
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 50) begin
      err_count++;
      final_report;
    end
  endtask : bus
  task automatic wait_rx;
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[spi_pkg::ST_RXF] !== 1'b1 && n < 400) begin
      bus(1'b0, spi_pkg::OFF_STAT, 32'h0);
      n++;
    end
    if (n == 400) begin
      err_count++;
      final_report;
    end
  endtask : wait_rx
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h700);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    bus(1'b1, 8'h0c, 32'h0);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h18, 32'h0);
    bus(1'b1, 8'h1c, 32'h7);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 8'h20, 32'(i * 4));
      bus(1'b1, 8'h00, 32'h3);
      bus(1'b1, 8'h08, 32'h1);
      wait_rx;
      // Select negation delay still running, so idle request is low
      chk({29'h0, irq[2:0]}, 32'h3);
      bus(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h3c);
      chk({24'h0, got}, i ? 32'h80 : 32'h01);
    end
    bus(1'b1, 8'h00, 32'h80);
    bus(1'b1, 8'h00, 32'h41);
    #3;
    // Slave frame with no transmit data loaded; link clock runs only here
    for (int b = 7; b >= 0; b--) begin
      lmosi = b inside {2, 3, 4, 5};
      #62.5 lsck = 1'b1;
      #62.5 lsck = 1'b0;
    end
    wait_rx;
    chk(rd & 32'h14, 32'h14);
    chk({28'h0, irq}, 32'h7);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h3c);
    // Another master selects us in multi-master mode: enable must drop
    bus(1'b1, 8'h00, 32'h80);
    bus(1'b1, 8'h00, 32'h07);
    lsel <= 1'b0;
    repeat (5) @(posedge clk);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h06);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h14, 32'h04);
    // Mid-run reset: outputs quiet, registers back to reset state
    rst_b <= 1'b0;
    @(posedge clk);
    chk(readdata, 32'h0);
    chk({13'h0, irq, waitrequest, pins_out}, 32'h4000);
    rst_b <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h22);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, spi_pkg::RST_CMD);
    final_report;
  end
endmodule : tb
`default_nettype wire
